// file: rtl/diag_evc_pkg.sv
// Purpose: constants and types for the transmit-side diagnostic event counters
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   printed sub-addresses are word indices; byte address is four times the index
package diag_evc_pkg;

  // register indices as printed, byte address = index * 4
  localparam logic [5:0]  IDX_CTRL       = 6'h00;
  localparam logic [5:0]  IDX_TX_FRAME   = 6'h16;
  localparam logic [5:0]  IDX_LATE_WARN  = 6'h18;
  localparam int          IDX_LSB        = 2;
  localparam int          IDX_W          = 6;

  localparam int          DATA_W         = 32;
  localparam int          REG_W          = 16;
  localparam int          CNT_W_DEF      = 12;
  localparam int          NUM_CNT        = 2;
  localparam int          CNT_TX_FRAME   = 0;
  localparam int          CNT_LATE_WARN  = 1;

  localparam int          CTRL_EN_BIT    = 0;
  localparam logic        CTRL_EN_RESET  = 1'b0;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // which register an address selects
  typedef enum logic [1:0] {
    SEL_NONE      = 2'b00,
    SEL_CTRL      = 2'b01,
    SEL_TX_FRAME  = 2'b10,
    SEL_LATE_WARN = 2'b11
  } reg_sel_t;

  // one-cycle event reports from the transceiver core
  typedef struct packed {
    logic frame_sent_event;
    logic late_delay_warning_event;
  } diag_evt_t;

endpackage : diag_evc_pkg

// file: rtl/diag_tx_event_counters.sv
// Purpose: frame-sent and late-delay-warning event counters behind an AXI4-Lite slave
// Assumes: event inputs are one-cycle pulses synchronous to clk
// Notes:   counters are read-only; writes to them answer OKAY and change nothing
//
// Summary of operation
// (R1) transmitted-frame counter is 12 bits in bits 11:0, plus one per frame sent
// (R2) frame counter advances once per frame-sent event report
// (R3) late-delay warning counter is 12 bits, plus one per warning event report
// (R4) only late-invoked delayed transmit or receive warnings count as warnings
// (R5) both counters move only while event-counter enable is set, else hold
// (R6) bits 15:12 of each counter register are reserved and read zero
// (R7) frame counter at index 0x16, warning counter at 0x18, read-only, reset zero
// (R8) a counter at its maximum wraps to zero on the next event
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module diag_tx_event_counters
  import diag_evc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = CNT_W_DEF
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire diag_evt_t           evt,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  if (CNT_W < 1 || CNT_W > REG_W || ADDR_W < IDX_LSB + IDX_W)
  begin : g_param_check
    $error("diag_tx_event_counters: unsupported CNT_W or ADDR_W");
  end

  function automatic reg_sel_t addr_sel(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[IDX_LSB +: IDX_W];
    // a shift, not a part-select, so an address bus with no spare upper bits still elaborates
    if (a[IDX_LSB-1:0] != '0 || (a >> (IDX_LSB + IDX_W)) != '0)
      addr_sel = SEL_NONE;
    else if (idx == IDX_CTRL)
      addr_sel = SEL_CTRL;
    else if (idx == IDX_TX_FRAME)
      addr_sel = SEL_TX_FRAME;
    else if (idx == IDX_LATE_WARN)
      addr_sel = SEL_LATE_WARN;
    else
      addr_sel = SEL_NONE;
  endfunction : addr_sel

  logic                    event_counter_enable;
  logic [CNT_W-1:0]        count [NUM_CNT];
  logic [NUM_CNT-1:0]      hit;
  logic                    aw_held;
  logic                    w_held;
  logic [ADDR_W-1:0]       aw_addr_q;
  logic [DATA_W-1:0]       w_data_q;
  logic [DATA_W/8-1:0]     w_strb_q;

  // event lines already carry only the qualifying causes; a late-power-up
  // warning travels on a separate line and never reaches this block
  assign hit[CNT_TX_FRAME]  = evt.frame_sent_event;          // [R2]
  assign hit[CNT_LATE_WARN] = evt.late_delay_warning_event;  // [R4]

  wire [CNT_W-1:0] tx_frame_sent_count      = count[CNT_TX_FRAME];
  wire [CNT_W-1:0] late_delay_warning_count = count[CNT_LATE_WARN];

  for (genvar i = 0; i < NUM_CNT; i++)
  begin : g_cnt
    // natural binary wrap: a saturated count would hide later activity
    logic [CNT_W-1:0] value;
    wire  [CNT_W-1:0] next_count = value + CNT_W'(1);  // [R8]
    assign count[i] = value;
    always_ff @(posedge clk)
    begin
      if (!rst_b)
        value <= '0;  // [R7]
      else if (event_counter_enable && hit[i])  // [R5]
        value <= next_count;  // [R1] [R3]
    end
  end

  // write channel: address and data taken in either order
  wire aw_hs      = s_axi_awvalid && s_axi_awready;
  wire w_hs       = s_axi_wvalid && s_axi_wready;
  wire aw_have    = aw_held || aw_hs;
  wire w_have     = w_held || w_hs;
  wire wr_fire    = aw_have && w_have;
  wire [ADDR_W-1:0]   wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  wire [DATA_W-1:0]   wr_data = w_held ? w_data_q : s_axi_wdata;
  wire [DATA_W/8-1:0] wr_strb = w_held ? w_strb_q : s_axi_wstrb;
  wire reg_sel_t      wr_sel  = addr_sel(wr_addr);
  wire ctrl_wr    = wr_fire && wr_sel == SEL_CTRL && wr_strb[CTRL_EN_BIT / 8];
  wire [1:0] next_bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      aw_held <= aw_have && !wr_fire;
      w_held  <= w_have && !wr_fire;
      if (aw_hs)
        aw_addr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= next_bresp;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      event_counter_enable <= CTRL_EN_RESET;
    else if (ctrl_wr)
      event_counter_enable <= wr_data[CTRL_EN_BIT];
  end

  // read channel: one read in flight, answer one cycle after the address
  wire reg_sel_t rd_sel = addr_sel(s_axi_araddr);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  logic [DATA_W-1:0] next_rdata;
  always_comb
  begin
    next_rdata = '0;  // [R6]
    case (rd_sel)
      SEL_CTRL:      next_rdata[CTRL_EN_BIT] = event_counter_enable;
      SEL_TX_FRAME:  next_rdata[CNT_W-1:0] = tx_frame_sent_count;  // [R7]
      SEL_LATE_WARN: next_rdata[CNT_W-1:0] = late_delay_warning_count;  // [R7]
      default:       next_rdata = '0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  frame_count_step_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    event_counter_enable && evt.frame_sent_event
      |=> tx_frame_sent_count == CNT_W'($past(tx_frame_sent_count) + 1'b1))
    else $error("frame counter did not advance on a frame-sent event");

  frame_count_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    !evt.frame_sent_event |=> $stable(tx_frame_sent_count))
    else $error("frame counter moved without a frame-sent event");

  warn_count_step_a: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    event_counter_enable && evt.late_delay_warning_event
      |=> late_delay_warning_count == CNT_W'($past(late_delay_warning_count) + 1'b1))
    else $error("warning counter did not advance on a warning event");

  warn_count_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    !evt.late_delay_warning_event |=> $stable(late_delay_warning_count))
    else $error("warning counter moved without a warning event");

  disabled_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    !event_counter_enable [*2] |-> $stable(tx_frame_sent_count) && $stable(late_delay_warning_count))
    else $error("counter changed while counting disabled");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    ar_hs && rd_sel inside {SEL_TX_FRAME, SEL_LATE_WARN}
      |=> s_axi_rvalid && s_axi_rdata[DATA_W-1:CNT_W] == '0)
    else $error("reserved counter bits read nonzero");

  read_value_a: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
    ar_hs && rd_sel == SEL_TX_FRAME
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[CNT_W-1:0] == $past(tx_frame_sent_count))
    else $error("frame counter read returned wrong value");

  count_wrap_a: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    event_counter_enable && evt.late_delay_warning_event && late_delay_warning_count == CNT_MAX
      |=> late_delay_warning_count == '0)
    else $error("warning counter failed to wrap to zero");

  write_resp_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_fire |=> s_axi_bvalid && s_axi_bresp == $past(next_bresp))
    else $error("write response missing or wrong");

  resp_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  frame_count_c: cover property (@(posedge clk) disable iff (!rst_b)
    event_counter_enable && evt.frame_sent_event);
  warn_wrap_c:   cover property (@(posedge clk) disable iff (!rst_b)
    event_counter_enable && evt.late_delay_warning_event && late_delay_warning_count == CNT_MAX);
  ctrl_write_c:  cover property (@(posedge clk) disable iff (!rst_b) ctrl_wr);
  cnt_read_c:    cover property (@(posedge clk) disable iff (!rst_b) ar_hs && rd_sel == SEL_LATE_WARN);

endmodule : diag_tx_event_counters
`default_nettype wire

// file: tb/diag_tx_event_counters_tb.sv
// Purpose: self-checking bench for the diagnostic event counters over AXI4-Lite
// Assumes: design outputs are read right after a rising edge, before that edge's updates land
// Notes:   random event pulses come from a fixed-seed xorshift; the bench keeps its own counts
`timescale 1ns/1ps
`default_nettype none
module diag_tx_event_counters_tb;
  import diag_evc_pkg::*;
  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  diag_evt_t   evt;
  logic [11:0] exp_tx, exp_lw;
  logic [31:0] seed;
  logic        en;
  int          num_errors, n_compared;

  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_TX   = {IDX_TX_FRAME, 2'b00};
  localparam logic [7:0] A_LW   = {IDX_LATE_WARN, 2'b00};

  diag_tx_event_counters uut (.clk(clk), .rst_b(rst_b), .evt(evt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // reserved and upper bits always read zero
  function automatic logic [31:0] exp_reg(input logic [11:0] c);
    return {20'h0_0000, c};
  endfunction : exp_reg

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic summarize();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic axi_write(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s, output logic [1:0] rs);
    // one edge of gap keeps the last call's release apart from this request
    @(posedge clk);
    awaddr  <= a;
    wdata   <= dv;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  // rnd=0 holds both events high, each held cycle counts once
  task automatic run_evt(input int n, input bit rnd);
    logic [1:0] v;
    repeat (n)
    begin
      @(posedge clk);
      v = rnd ? 2'(xs()) : 2'b11;
      evt.frame_sent_event         <= v[1];
      evt.late_delay_warning_event <= v[0];
      if (en)
      begin
        exp_tx = exp_tx + 12'(v[1]);
        exp_lw = exp_lw + 12'(v[0]);
      end
    end
    @(posedge clk);
    evt <= '0;
  endtask : run_evt

  task automatic check_regs();
    axi_read(A_TX, d, r);
    chk(d, exp_reg(exp_tx));
    chk_resp(r, RESP_OKAY);
    axi_read(A_LW, d, r);
    chk(d, exp_reg(exp_lw));
    chk_resp(r, RESP_OKAY);
  endtask : check_regs

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #(50 * 20000);
    num_errors++;
    summarize();
  end

  initial
  begin
    rst_b   = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    en      = 1'b0;
    awaddr  = '0;
    araddr  = '0;
    wdata   = '0;
    wstrb   = '0;
    exp_tx  = '0;
    exp_lw  = '0;
    evt     = '0;
    seed    = 32'h2477_2b8c;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    check_regs();
    run_evt(40, 1);
    check_regs();
    // enable bit ignores a write that lacks byte lane 0
    axi_write(A_CTRL, 32'h0000_0001, 4'he, r);
    chk_resp(r, RESP_OKAY);
    axi_read(A_CTRL, d, r);
    chk(d, 32'h0000_0000);
    axi_write(A_CTRL, xs() | 32'h0000_0001, 4'hf, r);
    chk_resp(r, RESP_OKAY);
    en = 1'b1;
    axi_read(A_CTRL, d, r);
    chk(d, 32'h0000_0001);
    run_evt(300, 1);
    check_regs();
    axi_write(A_TX, xs(), 4'hf, r);
    chk_resp(r, RESP_OKAY);
    axi_write(A_LW, 32'hffff_ffff, 4'hf, r);
    chk_resp(r, RESP_OKAY);
    check_regs();
    axi_write(A_TX + 8'h04, 32'h0000_0001, 4'hf, r);
    chk_resp(r, RESP_SLVERR);
    axi_read(A_TX + 8'h04, d, r);
    chk_resp(r, RESP_SLVERR);
    chk(d, 32'h0000_0000);
    axi_read(A_TX + 8'h02, d, r);
    chk_resp(r, RESP_SLVERR);
    // one full turn plus one forces both counters through 4095 to 0
    run_evt(4097, 0);
    check_regs();
    axi_write(A_CTRL, 32'h0000_0000, 4'hf, r);
    chk_resp(r, RESP_OKAY);
    en = 1'b0;
    run_evt(60, 1);
    check_regs();
    // reset after the runs must clear nonzero counts; the enable was already written off before it
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    exp_tx = '0;
    exp_lw = '0;
    check_regs();
    axi_read(A_CTRL, d, r);
    chk(d, 32'h0000_0000);
    summarize();
  end
endmodule : diag_tx_event_counters_tb
`default_nettype wire
